// [rtl/led_pwm_pkg.sv]
package led_pwm_pkg;

   // Channel count and counter widths
   localparam int CHANNELS = 4;
   localparam int DUTY_W = 8;
   localparam int STATE_W = 2;

   // Time base: 10 MHz system clock, 40 ns duty step
   localparam int CLK_PERIOD_NS = 100;
   localparam int DUTY_STEP_NS = 40;
   localparam int STEP_CYCLES_RAW = (DUTY_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STEP_CYCLES = (STEP_CYCLES_RAW < 1) ? 1 : STEP_CYCLES_RAW;
   localparam int STEP_DIV_W = 4;

   // Group timing in individual periods per group step
   localparam int DIM_WRAPS_PER_STEP = 2;
   localparam int BLINK_WRAPS_PER_STEP = 16;
   localparam int WRAP_CNT_W = 13;

   // Channel state codes
   localparam logic [1:0] STATE_OFF = 2'h0;
   localparam logic [1:0] STATE_ON = 2'h1;
   localparam logic [1:0] STATE_INDIV = 2'h2;
   localparam logic [1:0] STATE_GROUP = 2'h3;

   // Disabled output states
   localparam logic [1:0] DIS_LOW = 2'h0;
   localparam logic [1:0] DIS_HIGH_TOTEM = 2'h1;
   localparam logic [1:0] DIS_HIGH_Z = 2'h2;
   localparam logic [1:0] DIS_RESERVED = 2'h3;

   // Reset values
   localparam logic [7:0] DUTY_RESET = 8'h00;
   localparam logic [7:0] GROUP_DUTY_RESET = 8'hFF;
   localparam logic OE_N_RESET = 1'b1;

   typedef struct packed {
      logic upper;
      logic lower;
   } drive_t;

   typedef struct packed {
      logic       output_invert;
      logic       output_drive_type;
      logic [1:0] disabled_output_state;
      logic       group_blink;
   } mode_cfg_t;

   typedef enum logic [1:0] {
      GRP_DIM   = 2'b00,
      GRP_BLINK = 2'b01
   } group_mode_t;

endpackage

// [rtl/oe_pin_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module oe_pin_sync
   import led_pwm_pkg::*;
#(
   parameter logic RESET_LEVEL = OE_N_RESET
)
(
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst_b,
   // Pin and clean level
   input  wire logic pin,
   output var  logic level
);

   logic stage1;
   logic stage2;
   logic stage3;

   // Three-stage chain
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         stage1 <= RESET_LEVEL;
         stage2 <= RESET_LEVEL;
         stage3 <= RESET_LEVEL;
      end
      else
      begin
         stage1 <= pin;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // Accept a change once the last two stages agree
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         level <= RESET_LEVEL;
      else if (stage2 == stage3)
         level <= stage3;
   end

endmodule
`default_nettype wire

// [rtl/group_pwm_gen.sv]
`timescale 1ns/1ns
`default_nettype none
module group_pwm_gen
   import led_pwm_pkg::*;
#(
   parameter int DIM_WRAPS   = DIM_WRAPS_PER_STEP,
   parameter int BLINK_WRAPS = BLINK_WRAPS_PER_STEP
)
(
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              rst_b,
   // Individual period wrap and mode
   input  wire logic              period_wrap,
   input  wire group_mode_t       mode,
   input  wire logic [7:0]        group_freq,
   // Group phase
   output var  logic [DUTY_W-1:0] group_count,
   output var  logic              group_wrap
);

   logic [WRAP_CNT_W-1:0] wrap_count;
   logic [WRAP_CNT_W-1:0] wraps_per_step;
   logic                  step;

   // Blink step length scales with the period setting
   always_comb
   begin
      if (mode == GRP_BLINK)
         wraps_per_step = WRAP_CNT_W'(({5'h00, group_freq} + 13'h0001) * BLINK_WRAPS);
      else
         wraps_per_step = WRAP_CNT_W'(DIM_WRAPS);
   end

   assign step = period_wrap && (wrap_count >= wraps_per_step - 13'h0001);

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         wrap_count <= '0;
      else if (step)
         wrap_count <= '0;
      else if (period_wrap)
         wrap_count <= wrap_count + 13'h0001;
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         group_count <= '0;
         group_wrap <= 1'b0;
      end
      else
      begin
         group_wrap <= step && (group_count == 8'hFF);
         if (step)
            group_count <= group_count + 8'h01;
      end
   end

endmodule
`default_nettype wire

// [rtl/led_output_pwm_stage.sv]
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Inversion alters the pins only while the output enable is low.
// - With output enable high, the disabled-output-state field and the drive type set every pin.
// - Uninverted, code 00 turns the lower transistor off and code 01 pulls it low; inversion swaps them.
// - Open-drain never turns the upper transistor on; totem-pole drives both complementarily while outputs are enabled.
// - In code 10 with inversion, the low time is one minus the channel duty.
// - Code 11 with inversion drives the lower transistor by the inverted individual-and-group term.
// - Each channel makes a fixed-rate brightness signal with an 8-bit, 256-step duty.
// - One shared group signal overlays every channel that uses code 11.
// - Dimming mode runs the group signal at a fixed rate with an 8-bit duty.
// - Blinking mode makes the group period programmable in 256 steps with its own duty.
// - The brightness pulse lasts the duty value times one 100 ns step, the 40 ns step rounded up to one clock.
// - In dimming mode each group duty step spans two individual periods.
// - State codes mean off, fully on, individual duty, and individual plus group.
// - Disabled field: 00 low, 01 high if totem else released, 10 released, 11 reserved.
module led_output_pwm_stage
   import led_pwm_pkg::*;
#(
   parameter int NUM_CH    = CHANNELS,
   parameter int STEP_DIV  = STEP_CYCLES,
   parameter int DIM_STEP  = DIM_WRAPS_PER_STEP,
   parameter int BLINK_STEP = BLINK_WRAPS_PER_STEP
)
(
   // Clock and reset
   input  wire logic                      clock,
   input  wire logic                      rst_b,
   // Output enable pin
   input  wire logic                      output_enable_n,
   // Mode configuration
   input  wire mode_cfg_t                 mode_cfg,
   // Channel settings
   input  wire logic [NUM_CH*STATE_W-1:0] led_state_select,
   input  wire logic [NUM_CH*DUTY_W-1:0]  channel_duty,
   // Group settings
   input  wire logic [DUTY_W-1:0]         group_duty,
   input  wire logic [DUTY_W-1:0]         group_freq,
   // LED pins
   output var  logic [NUM_CH-1:0]         led_output_pin_o,
   output var  logic [NUM_CH-1:0]         led_output_pin_oe,
   // Transistor view
   output var  drive_t [NUM_CH-1:0]       led_drive,
   // Status
   output var  logic                      outputs_enabled,
   output var  logic                      period_start,
   output var  logic                      group_active,
   output var  logic [DUTY_W-1:0]         group_phase
);

   logic                  oe_n_clean;
   logic [STEP_DIV_W-1:0] step_div;
   logic                  step_en;
   logic [DUTY_W-1:0]     duty_count;
   logic                  period_wrap;
   logic [DUTY_W-1:0]     group_count;
   logic                  group_wrap;
   logic [DUTY_W-1:0]     group_duty_live;
   logic                  group_gate;
   group_mode_t           group_mode;
   drive_t [NUM_CH-1:0]   next_drive;
   logic [NUM_CH-1:0]     next_pin_o;
   logic [NUM_CH-1:0]     next_pin_oe;

   // Drive decode while outputs are enabled
   function automatic drive_t enabled_drive(input logic [1:0] code,
                                            input logic       indiv,
                                            input logic       grp,
                                            input logic       invert,
                                            input logic       totem);
      logic   pull_low;
      drive_t d;
      pull_low = 1'b0;
      d = '0;
      case (code)
         STATE_OFF:   pull_low = invert;
         STATE_ON:    pull_low = !invert;
         STATE_INDIV: pull_low = invert ? !indiv : indiv;
         STATE_GROUP: pull_low = invert ? !(indiv && grp)
                                        : (indiv && grp);
         default:     pull_low = 1'b0;
      endcase
      d.lower = pull_low;
      d.upper = totem && !pull_low;
      return d;
   endfunction

   // Drive decode while outputs are disabled
   function automatic drive_t disabled_drive(input logic [1:0] field,
                                             input logic       totem);
      drive_t d;
      d = '0;
      case (field)
         DIS_LOW:        d.lower = 1'b1;
         DIS_HIGH_TOTEM: d.upper = totem;
         DIS_HIGH_Z:     d = '0;
         default:        d = '0;
      endcase
      return d;
   endfunction

   // Output enable pin conditioning
   oe_pin_sync #(
      .RESET_LEVEL (OE_N_RESET)
   ) u_oe_sync (
      .clock (clock),
      .rst_b (rst_b),
      .pin   (output_enable_n),
      .level (oe_n_clean)
   );

   // Duty step enable divider
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         step_div <= '0;
      else if (step_div >= STEP_DIV_W'(STEP_DIV - 1))
         step_div <= '0;
      else
         step_div <= step_div + 4'h1;
   end

   assign step_en = (step_div >= STEP_DIV_W'(STEP_DIV - 1));

   // Free-running individual counter
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         duty_count <= '0;
      else if (step_en)
         duty_count <= duty_count + 8'h01;
   end

   assign period_wrap = step_en && (duty_count == 8'hFF);

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         period_start <= 1'b0;
      else
         period_start <= period_wrap;
   end

   // Shared group counter
   assign group_mode = mode_cfg.group_blink ? GRP_BLINK : GRP_DIM;

   group_pwm_gen #(
      .DIM_WRAPS   (DIM_STEP),
      .BLINK_WRAPS (BLINK_STEP)
   ) u_group (
      .clock       (clock),
      .rst_b       (rst_b),
      .period_wrap (period_wrap),
      .mode        (group_mode),
      .group_freq  (group_freq),
      .group_count (group_count),
      .group_wrap  (group_wrap)
   );

   // Group duty taken at group wrap to avoid torn pulses
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         group_duty_live <= GROUP_DUTY_RESET;
      else if (group_wrap)
         group_duty_live <= group_duty;
   end

   assign group_gate = (group_count < group_duty_live);

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         group_active <= 1'b0;
         group_phase <= '0;
      end
      else
      begin
         group_active <= group_gate;
         group_phase <= group_count;
      end
   end

   // Per-channel duty shadow and compare
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++)
      begin : g_chan
         logic [DUTY_W-1:0]  duty_live;
         logic               indiv;
         logic [STATE_W-1:0] code;
         drive_t             nd;

         // Duty changes take effect at the next period start
         always_ff @(posedge clock or negedge rst_b)
         begin
            if (!rst_b)
               duty_live <= DUTY_RESET;
            else if (period_wrap)
               duty_live <= channel_duty[ch*DUTY_W +: DUTY_W];
         end

         assign indiv = (duty_count < duty_live);
         assign code = led_state_select[ch*STATE_W +: STATE_W];

         always_comb
         begin
            if (oe_n_clean)
               nd = disabled_drive(mode_cfg.disabled_output_state,
                                   mode_cfg.output_drive_type);
            else
               nd = enabled_drive(code, indiv, group_gate,
                                  mode_cfg.output_invert,
                                  mode_cfg.output_drive_type);
         end

         assign next_drive[ch] = nd;
         assign next_pin_o[ch] = next_drive[ch].upper;
         assign next_pin_oe[ch] = next_drive[ch].upper || next_drive[ch].lower;
      end
   endgenerate

   // Registered pin drive
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         led_drive <= '0;
         led_output_pin_o <= '0;
         led_output_pin_oe <= '0;
      end
      else
      begin
         led_drive <= next_drive;
         led_output_pin_o <= next_pin_o;
         led_output_pin_oe <= next_pin_oe;
      end
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         outputs_enabled <= 1'b0;
      else
         outputs_enabled <= !oe_n_clean;
   end

endmodule
`default_nettype wire

// [tb/led_load.sv]
`timescale 1ns/1ns
`default_nettype none
module led_load
   import led_pwm_pkg::*;
(
   // Stage pin
   input  wire logic [CHANNELS-1:0] pin_o,
   input  wire logic [CHANNELS-1:0] pin_oe,
   // Cathode level
   output var  logic [CHANNELS-1:0] level
);
   // Released pin pulled to supply by the LED resistor
   always_comb
   begin
      for (int i = 0; i < CHANNELS; i++)
         level[i] = pin_oe[i] ? pin_o[i] : 1'b1;
   end
endmodule
`default_nettype wire

// [tb/led_stage_sva.sv]
`timescale 1ns/1ns
`default_nettype none
module led_stage_sva
   import led_pwm_pkg::*;
#(
   parameter int STEP_DIV   = STEP_CYCLES,
   parameter int DIM_STEP   = DIM_WRAPS_PER_STEP,
   parameter int BLINK_STEP = BLINK_WRAPS_PER_STEP
)
(
   // Clock and reset
   input wire logic         clock,
   input wire logic         rst_b,
   // Settings
   input wire mode_cfg_t    mode_cfg,
   input wire logic [7:0]   led_state_select,
   input wire logic [7:0]   group_freq,
   // Outputs
   input wire logic [3:0]   led_output_pin_o,
   input wire logic [3:0]   led_output_pin_oe,
   input wire drive_t [3:0] led_drive,
   input wire logic         outputs_enabled,
   input wire logic         period_start,
   input wire logic         group_active,
   input wire logic [7:0]   group_phase
);
   localparam int PER = 256 * STEP_DIV;
   localparam int PM1 = PER - 1;
   logic [3:0]  lw;
   logic [3:0]  up;
   logic [31:0] since;
   logic        clean;
   logic [7:0]  ph_q;
   logic [8:0]  gs_q;
   mode_cfg_t   cfg_q;
   logic [1:0]  sel_q;
   logic        dis_on;
   logic        dis_hi;
   logic [1:0]  age;
   logic        alive;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         lw[i] = led_drive[i].lower;
         up[i] = led_drive[i].upper;
      end
      dis_hi = cfg_q.disabled_output_state == DIS_HIGH_TOTEM && cfg_q.output_drive_type;
      dis_on = cfg_q.disabled_output_state == DIS_LOW || dis_hi;
   end

   always_ff @(posedge clock)
   begin
      cfg_q <= mode_cfg;
      sel_q <= led_state_select[1:0];
      ph_q <= group_phase;
      gs_q <= {mode_cfg.group_blink, group_freq};
   end

   // Cycles since reset release, so first samples after reset are skipped
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         age <= 2'h0;
      else if (age != 2'h3)
         age <= age + 2'h1;
   end

   assign alive = (age == 2'h3);

   // Cycles since the group phase last moved
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         since <= 32'h0;
         clean <= 1'b0;
      end
      else if (group_phase != ph_q)
      begin
         since <= 32'h1;
         clean <= {mode_cfg.group_blink, group_freq} == gs_q;
      end
      else
      begin
         since <= since + 32'h1;
         if ({mode_cfg.group_blink, group_freq} != gs_q)
            clean <= 1'b0;
      end
   end

   chk_od_upper: assert property (!mode_cfg.output_drive_type |=> up == 4'h0)
      else $error("upper on in open drain");
   chk_totem_pair: assert property (
      alive && outputs_enabled && mode_cfg.output_drive_type ##1 outputs_enabled |-> up == ~lw)
      else $error("totem not complementary");
   chk_pin_view: assert property (
      led_output_pin_oe == (up | lw) && (led_output_pin_o & led_output_pin_oe) == up)
      else $error("pin and transistors disagree");
   chk_off_state: assert property (alive && !outputs_enabled ##1 !outputs_enabled
      |-> led_output_pin_oe == {4{dis_on}} && (led_output_pin_o & led_output_pin_oe) == {4{dis_hi}})
      else $error("disabled state wrong");
   chk_static_code: assert property (
      alive && outputs_enabled ##1 outputs_enabled && !sel_q[1]
      |-> lw[0] == (sel_q[0] ^ cfg_q.output_invert))
      else $error("static code drive wrong");
   chk_group_gate: assert property (
      alive && !group_active && outputs_enabled ##1 !group_active && outputs_enabled
      && sel_q == STATE_GROUP |-> lw[0] == cfg_q.output_invert)
      else $error("group gate ignored");
   chk_period_len: assert property (
      period_start |=> !period_start ##[PM1:PM1] period_start)
      else $error("period length wrong");
   chk_phase_span: assert property (alive && group_phase != ph_q && clean
      |-> since == (mode_cfg.group_blink ? (group_freq + 32'h1) * BLINK_STEP * PER : DIM_STEP * PER))
      else $error("group step span wrong");

   cov_period: cover property (period_start);
   cov_grp_off: cover property ($fell(group_active));
   cov_enable: cover property ($rose(outputs_enabled));
endmodule

bind led_output_pwm_stage led_stage_sva #(.STEP_DIV(STEP_DIV), .DIM_STEP(DIM_STEP),
   .BLINK_STEP(BLINK_STEP)) i_sva (.clock, .rst_b, .mode_cfg, .led_state_select,
   .group_freq, .led_output_pin_o, .led_output_pin_oe, .led_drive, .outputs_enabled,
   .period_start, .group_active, .group_phase);
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb
   import led_pwm_pkg::*;
;
   logic         clock;
   logic         rst_b;
   logic         output_enable_n;
   mode_cfg_t    mode_cfg;
   logic [7:0]   led_state_select;
   logic [31:0]  channel_duty;
   logic [7:0]   group_duty;
   logic [7:0]   group_freq;
   logic [3:0]   led_output_pin_o;
   logic [3:0]   led_output_pin_oe;
   logic [3:0]   level;
   drive_t [3:0] led_drive;
   logic         outputs_enabled;
   logic         period_start;
   logic         group_active;
   logic [7:0]   group_phase;
   int           bad_count;
   int           n_compared;
   int           cnt;

   led_output_pwm_stage #(.BLINK_STEP(1)) i_dut (.clock, .rst_b, .output_enable_n,
      .mode_cfg, .led_state_select, .channel_duty, .group_duty, .group_freq,
      .led_output_pin_o, .led_output_pin_oe, .led_drive, .outputs_enabled,
      .period_start, .group_active, .group_phase);
   led_load i_load (.pin_o(led_output_pin_o), .pin_oe(led_output_pin_oe), .level);

   initial
   begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   task automatic stop_test();
      if (bad_count == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic check(input logic ok, input string what);
      n_compared++;
      if (ok !== 1'b1)
      begin
         bad_count++;
         $display("mismatch at %0t: %s", $time, what);
      end
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clock);
      @(negedge clock);
   endtask

   task automatic count_low(input int ch, input int n);
      cnt = 0;
      repeat (n)
      begin
         @(negedge clock);
         if (led_drive[ch].lower === 1'b1)
            cnt++;
      end
   endtask

   task automatic test_disabled();
      logic dd;
      for (int k = 0; k < 16; k++)
      begin
         @(posedge clock);
         mode_cfg <= {k[3], k[2], k[1:0], 1'b0};
         led_state_select <= 8'h55;
         settle(3);
         dd = k[1:0] == DIS_LOW || (k[1:0] == DIS_HIGH_TOTEM && k[2]);
         check(led_output_pin_oe === {4{dd}}, "disabled drive");
         check(level === {4{k[1:0] != DIS_LOW}}, "disabled level");
      end
   endtask

   task automatic test_static();
      logic el;
      @(posedge clock);
      output_enable_n <= 1'b0;
      for (int k = 0; k < 8; k++)
      begin
         @(posedge clock);
         mode_cfg <= {k[1], k[2], DIS_LOW, 1'b0};
         led_state_select <= {4{1'b0, k[0]}};
         settle(8);
         el = k[0] ^ k[1];
         check(led_drive === {4{k[2] & !el, el}}, "static drive");
         check(level === {4{!el}} && outputs_enabled === 1'b1, "static level");
      end
   endtask

   task automatic test_pwm();
      int dv[4] = '{0, 1, 4, 255};
      for (int inv = 0; inv < 2; inv++)
      begin
         @(posedge clock);
         mode_cfg <= {inv[0], 1'b0, DIS_LOW, 1'b0};
         led_state_select <= {4{STATE_INDIV}};
         channel_duty <= 32'hFF04_0100;
         settle(520);
         for (int ch = 0; ch < 4; ch++)
         begin
            count_low(ch, 256);
            check(cnt == (inv ? 256 - dv[ch] : dv[ch]), "pwm low time");
         end
      end
   endtask

   task automatic test_group();
      @(posedge clock);
      mode_cfg <= {1'b0, 1'b0, DIS_LOW, 1'b1};
      led_state_select <= {4{STATE_GROUP}};
      group_duty <= 8'h02;
      group_freq <= 8'h00;
      settle(1);
      for (int i = 0; i < 70000 && group_phase !== 8'h00; i++)
         @(negedge clock);
      settle(128);
      count_low(2, 256);
      check(cnt == 4 && group_active === 1'b1, "group on pulses");
      for (int i = 0; i < 600 && group_phase !== 8'h02; i++)
         @(negedge clock);
      @(posedge clock);
      mode_cfg <= {1'b1, 1'b0, DIS_LOW, 1'b1};
      settle(128);
      count_low(2, 256);
      check(cnt == 256 && group_active === 1'b0, "group off inverted");
   endtask

   initial
   begin
      #9000000;
      bad_count++;
      stop_test();
   end

   initial
   begin
      rst_b = 1'b0;
      output_enable_n = 1'b1;
      mode_cfg = '0;
      led_state_select = 8'h00;
      channel_duty = 32'h0;
      group_duty = 8'hFF;
      group_freq = 8'h00;
      bad_count = 0;
      n_compared = 0;
      repeat (12) @(posedge clock);
      rst_b <= 1'b1;
      test_disabled();
      test_static();
      test_pwm();
      test_group();
      stop_test();
   end
endmodule
`default_nettype wire
